//--- shared/irq_vec_consts.svh
// Constants for the interrupt priority and vectoring block.
// Assumes it is included by the package by bare name.
`ifndef IRQ_VEC_CONSTS_SVH
`define IRQ_VEC_CONSTS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define IRQ_ENABLE_ADDR 8'ha8
`define IRQ_PRIORITY_ADDR 8'hb8
`define EXT_IRQ_ENABLE_ADDR 8'he6
`define EXT_IRQ_PRIORITY_ADDR 8'hf6
`define IRQ_STATUS_ADDR 8'hc0
`define IRQ_MASK_ADDR 8'hc1
`define IRQ_PENDING_LO_ADDR 8'hc2
`define IRQ_PENDING_HI_ADDR 8'hc3

// ****************************************************************
// Reset values and fields
// ****************************************************************
`define IRQ_ENABLE_RST 8'h00
`define IRQ_PRIORITY_RST 8'h80
`define EXT_REG_RST 8'h00
`define GLOBAL_EN_BIT 7
`define SERIAL_EN_BIT 6
`define RESERVED_SRC_MASK 15'h2100
`define HW_CLEAR_MASK 15'h000f

// ****************************************************************
// Vectors and timing
// ****************************************************************
`define RESET_VECTOR 16'h0000
`define VECTOR_BASE 16'h0003
`define VECTOR_STEP_SHIFT 3
`define DETECT_CYCLES 1
`define CALL_CYCLES 4
`define RETURN_CYCLES 5
`define DIVIDE_CYCLES 8

`endif

//--- shared/irq_vec_pkg.sv
// Types for the interrupt priority and vectoring block.
// Assumes the constants header sits beside it.
package irq_vec_pkg;
   `include "irq_vec_consts.svh"

   // Controller sequencing states
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_CALL,
      ST_SERVICE,
      ST_RETURN,
      ST_AFTER_RETURN
   } ctrl_state_t;

   typedef logic [3:0] src_num_t;
endpackage : irq_vec_pkg

//--- testbench/core_model.sv
// Core model: runs instructions, obeys long calls, runs a short routine, returns.
// Assumes the block pulses its call output for one cycle per take.
`timescale 1ns/10ps
module core_model
   import irq_vec_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic reset_n_in,
   // Block side and pacing
   input wire logic call_in,
   input wire logic slow_in,
   output logic instr_done_out,
   output logic return_out
);
   int wait_q, rem, saved, depth;
   // Two cycle instructions when fast; divides of eight cycles when slow
   always @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         instr_done_out <= 1'b0;
         return_out <= 1'b0;
         wait_q = 1;
         rem = 0;
         saved = 0;
         depth = 0;
      end else begin
         instr_done_out <= 1'b0;
         return_out <= 1'b0;
         if (call_in) begin
            saved = rem;
            rem = 6;
            depth++;
            wait_q = 3;
         end else if (wait_q > 0) begin
            wait_q--;
         end else if (depth > 0 && rem == 0) begin
            return_out <= 1'b1;
            depth--;
            rem = saved;
            saved = 0;
            wait_q = slow_in ? 7 : 0;
         end else begin
            instr_done_out <= 1'b1;
            rem = (depth > 0) ? rem - 1 : 0;
            wait_q = (depth > 0 && rem == 0) ? 4 : (slow_in ? 7 : 1);
         end
      end
   end
endmodule : core_model

//--- testbench/irq_vec_chk.sv
// Checker for the interrupt vectoring block.
// Assumes it is bound into irq_priority_vectoring.
`timescale 1ns/10ps
module irq_vec_chk
   import irq_vec_pkg::*;
(
   // ****
   // Watched ports
   // ****
   input wire logic ref_clk_in,
   input wire logic reset_n_in,
   input wire logic [7:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   input wire logic [7:0] reg_rdata_out,
   input wire logic instr_done_in,
   input wire logic return_from_interrupt_in,
   input wire logic long_call_to_vector_out,
   input wire logic [15:0] vector_addr_out,
   input wire logic in_service_out
);
   logic [7:0] en_q;
   // Shadow of the enable register, kept from bus writes
   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         en_q <= 8'h00;
      end else if (reg_wr_in && reg_addr_in == 8'ha8) begin
         en_q <= reg_wdata_in;
      end
   end
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!reset_n_in);
   // A take is an instruction end followed by the call pulse
   sequence take_s;
      instr_done_in ##1 long_call_to_vector_out;
   endsequence
   call_pulse_a: assert property (long_call_to_vector_out |=> !long_call_to_vector_out)
      else $error("call pulse longer than one cycle");
   // Four call cycles after the take, then one more for the registered flag
   service_entry_a: assert property (take_s |-> ##5 in_service_out)
      else $error("service not entered five cycles after call");
   call_cause_a: assert property (long_call_to_vector_out |-> $past(instr_done_in))
      else $error("call without an instruction end");
   global_gate_a: assert property (long_call_to_vector_out |-> $past(en_q[7]))
      else $error("call while global enable off");
   vector_map_a: assert property (long_call_to_vector_out |-> vector_addr_out[2:0] == 3'h3
      && vector_addr_out <= 16'h0073 && vector_addr_out != 16'h0043 && vector_addr_out != 16'h006b)
      else $error("vector outside the map");
   vector_hold_a: assert property (!long_call_to_vector_out |-> $stable(vector_addr_out))
      else $error("vector moved without a call");
   readback_a: assert property ($past(reg_rd_in && reg_addr_in == 8'ha8)
      |-> reg_rdata_out == $past(en_q)) else $error("enable readback wrong");
   return_gap_a: assert property (return_from_interrupt_in |=> !long_call_to_vector_out)
      else $error("call right after return");
endmodule : irq_vec_chk

bind irq_priority_vectoring irq_vec_chk chk (.ref_clk_in, .reset_n_in, .reg_addr_in,
   .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .instr_done_in,
   .return_from_interrupt_in, .long_call_to_vector_out, .vector_addr_out, .in_service_out);

//--- testbench/testbench.sv
// Self-checking bench for the interrupt vectoring block.
// Assumes the core model and the checker are compiled before it.
`timescale 1ns/10ps
module testbench import irq_vec_pkg::*;;
   logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, x0 = 1'b0, x1 = 1'b0, slow = 1'b0;
   logic [7:0] addr = 8'h00, wdat = 8'h00, rdat;
   logic [14:0] ev = 15'h0000;
   logic done, ret, call, insvc, irq;
   logic [15:0] vec;
   int error_cnt = 0, n_tests = 0, k;
   // Clock
   initial forever #5 clk = ~clk;
   irq_priority_vectoring dut (.ref_clk_in(clk), .reset_n_in(rst_n), .reg_addr_in(addr),
      .reg_wdata_in(wdat), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdat),
      .external_irq_zero_in(x0), .external_irq_one_in(x1), .src_event_in(ev),
      .instr_done_in(done), .return_from_interrupt_in(ret), .long_call_to_vector_out(call),
      .vector_addr_out(vec), .in_service_out(insvc), .irq_out(irq));
   core_model core (.ref_clk_in(clk), .reset_n_in(rst_n), .call_in(call), .slow_in(slow),
      .instr_done_out(done), .return_out(ret));
   // ****
   // Tasks
   // ****
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr8(input logic [7:0] a, input logic [7:0] d);
      addr <= a;
      wdat <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      @(posedge clk);
   endtask : wr8
   task automatic rd8(input logic [7:0] a, input logic [7:0] exp);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(posedge clk);
      chk({8'h00, rdat}, {8'h00, exp});
   endtask : rd8
   task automatic pulse(input int n);
      ev <= 15'h0001 << n;
      @(posedge clk);
      ev <= 15'h0000;
   endtask : pulse
   // Bounded wait; a missing call fails through the top bit
   task automatic wait_call(input logic [15:0] exp);
      k = 0;
      while (call !== 1'b1 && k < 90) begin
         @(posedge clk);
         k++;
      end
      chk({call, vec[14:0]}, {1'b1, exp[14:0]});
      @(posedge clk);
   endtask : wait_call
   task automatic quiet(input int n);
      logic seen;
      seen = 1'b0;
      repeat (n) begin
         @(posedge clk);
         seen |= call;
      end
      chk({15'h0000, seen}, 16'h0000);
   endtask : quiet
   task automatic drain();
      // The routine flag rises some cycles after the call; wait for it first
      k = 0;
      while (insvc !== 1'b1 && k < 8) begin
         @(posedge clk);
         k++;
      end
      k = 0;
      while (insvc !== 1'b0 && k < 200) begin
         @(posedge clk);
         k++;
      end
      repeat (12) @(posedge clk);
   endtask : drain
   task automatic tally_and_finish();
      $display("errors %0d checks %0d", error_cnt, n_tests);
      if (error_cnt == 0 && n_tests > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : tally_and_finish
   // ****
   // Tests
   // ****
   initial begin
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      rd8(8'ha8, 8'h00);
      rd8(8'hb8, 8'h80);
      rd8(8'h10, 8'h00);
      chk(vec, 16'h0000);
      // Flag sets while globally off, then is taken
      wr8(8'ha8, 8'h10);
      pulse(4);
      quiet(20);
      rd8(8'hc2, 8'h10);
      wr8(8'ha8, 8'h90);
      wait_call(16'h0023);
      rd8(8'hc2, 8'h10);
      wr8(8'hc2, 8'h10);
      chk({15'h0000, irq}, 16'h0000);
      wr8(8'hc1, 8'h01);
      repeat (2) @(posedge clk);
      chk({15'h0000, irq}, 16'h0001);
      wr8(8'hc0, 8'h01);
      repeat (2) @(posedge clk);
      chk({15'h0000, irq}, 16'h0000);
      drain();
      // Every source alone: enable bit, vector, hardware clear
      for (int n = 0; n < 15; n++) begin
         if (n == 8 || n == 13) continue;
         wr8(8'ha8, n < 7 ? 8'h80 | (8'h01 << n) : 8'h80);
         wr8(8'he6, n < 7 ? 8'h00 : 8'h01 << (n - 7));
         x0 <= (n == 0);
         x1 <= (n == 2);
         if (n != 0 && n != 2) pulse(n);
         wait_call(16'h0003 + 16'(8 * n));
         x0 <= 1'b0;
         x1 <= 1'b0;
         rd8(n < 8 ? 8'hc2 : 8'hc3, n < 4 ? 8'h00 : 8'h01 << (n % 8));
         wr8(n < 8 ? 8'hc2 : 8'hc3, 8'h01 << (n % 8));
         drain();
      end
      // Reserved slots stay silent
      wr8(8'ha8, 8'hff);
      wr8(8'he6, 8'hff);
      ev <= 15'h2100;
      @(posedge clk);
      ev <= 15'h0000;
      quiet(30);
      rd8(8'hc3, 8'h00);
      // Tie at one level, then return followed by a divide
      wr8(8'ha8, 8'h8a);
      wr8(8'he6, 8'h00);
      slow <= 1'b1;
      ev <= 15'h000a;
      @(posedge clk);
      ev <= 15'h0000;
      wait_call(16'h000b);
      k = 0;
      while (ret !== 1'b1 && k < 200) begin
         @(posedge clk);
         k++;
      end
      k = 0;
      while (call !== 1'b1 && k < 40) begin
         @(posedge clk);
         k++;
      end
      chk(16'(k), 16'd9);
      chk(vec, 16'h001b);
      slow <= 1'b0;
      drain();
      // High preempts low; an equal low request waits
      wr8(8'hb8, 8'h20);
      wr8(8'ha8, 8'hb2);
      pulse(4);
      wait_call(16'h0023);
      wr8(8'hc2, 8'h10);
      pulse(1);
      quiet(3);
      pulse(5);
      wait_call(16'h002b);
      wr8(8'hc2, 8'h20);
      wait_call(16'h000b);
      drain();
      // Reset in mid-service wins over everything
      pulse(4);
      wait_call(16'h0023);
      wr8(8'hc2, 8'h10);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      chk({call, insvc, vec[13:0]}, 16'h0000);
      rst_n <= 1'b1;
      pulse(4);
      quiet(20);
      tally_and_finish();
   end
   // Watchdog well beyond the expected run
   initial begin
      repeat (6000) @(posedge clk);
      error_cnt++;
      tally_and_finish();
   end
endmodule : testbench

//--- verilog/irq_arbiter.sv
// Priority arbiter: picks the lowest numbered request of the best level.
// Assumes requests are already enable-qualified and on the same clock.
`timescale 1ns/10ps
module irq_arbiter
   import irq_vec_pkg::*;
#(
   parameter int NUM_SRC = 15
) (
   // Qualified requests and their levels
   input wire logic [NUM_SRC-1:0] req_in,
   input wire logic [NUM_SRC-1:0] high_in,
   // Winner
   output logic valid_out,
   output logic win_high_out,
   output logic [3:0] win_num_out
);
   logic [NUM_SRC-1:0] hi_req;
   logic [NUM_SRC-1:0] use_req;

   // High level requests win first, then fixed order inside a level
   always_comb begin
      hi_req = req_in & high_in;
      use_req = (|hi_req) ? hi_req : req_in;
      win_high_out = |hi_req;
      valid_out = |req_in;
      win_num_out = 4'h0;
      for (int i = NUM_SRC - 1; i >= 0; i--) begin
         if (use_req[i]) begin
            win_num_out = 4'(i);
         end
      end
   end
endmodule : irq_arbiter

//--- verilog/irq_priority_vectoring.sv
// Interrupt sampling, priority decode and vectoring for a small core.
// Assumes pending events are synchronous one-cycle pulses except the two
// external pins, and the core strobes return and instruction ends.
//
// How it works
// - Sample and decode requests every clock cycle
// - Detect one cycle, then four-cycle long call
// - One instruction runs after return before call
// - Return five cycles, divide eight for latency
// - Equal or higher level active holds requests
// - Vector is 0x0003 plus eight times number
// - One enable and priority bit per source
// - Global enable bit seven overrides all masks
// - High preempts low; lowest number wins ties
// - Vectoring clears external and timer0/1 flags
// - Flags set even while source disabled
`timescale 1ns/10ps
module irq_priority_vectoring
   import irq_vec_pkg::*;
#(
   parameter int NUM_SRC = 15
) (
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic reset_n_in,
   // Register port
   input wire logic [7:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [7:0] reg_rdata_out,
   // Interrupt sources: external pins and peripheral event pulses
   input wire logic external_irq_zero_in,
   input wire logic external_irq_one_in,
   input wire logic [NUM_SRC-1:0] src_event_in,
   // Core handshake
   input wire logic instr_done_in,
   input wire logic return_from_interrupt_in,
   output logic long_call_to_vector_out,
   output logic [15:0] vector_addr_out,
   output logic in_service_out,
   // Summary interrupt
   output logic irq_out
);
   // ****************************************************************
   // Registers and pin synchronisers
   // ****************************************************************
   logic [7:0] irq_enable_reg_q;
   logic [7:0] irq_priority_reg_q;
   logic [7:0] ext_irq_enable_reg_q;
   logic [7:0] ext_irq_priority_reg_q;
   logic [NUM_SRC-1:0] pending_q;
   logic [1:0] ext0_sync_q;
   logic [1:0] ext1_sync_q;
   logic ext0_prev_q;
   logic ext1_prev_q;
   logic [1:0] stat_q;
   logic [1:0] mask_q;
   ctrl_state_t state_q;
   logic [2:0] call_cnt_q;
   logic active_low_q;
   logic active_high_q;
   logic call_high_q;
   logic [15:0] vector_q;
   logic call_q;

   logic [NUM_SRC-1:0] enable_vec;
   logic [NUM_SRC-1:0] prio_vec;
   logic [NUM_SRC-1:0] req_vec;
   logic arb_valid;
   logic arb_high;
   logic [3:0] arb_num;
   logic take;
   logic [NUM_SRC-1:0] ext_set;
   logic [NUM_SRC-1:0] hw_clear;
   logic [NUM_SRC-1:0] sw_clear;

   localparam int CALL_LEN = `CALL_CYCLES;

   // Map source number to its enable or priority bit
   function automatic logic [NUM_SRC-1:0] map_bits(input logic [7:0] base,
                                                   input logic [7:0] ext);
      logic [NUM_SRC-1:0] v;
      v = '0;
      v[6:0] = base[6:0];
      v[7] = ext[0];
      v[14:9] = ext[7:2];
      return v;
   endfunction : map_bits

   // Vector of a source number
   function automatic logic [15:0] vec_of(input logic [3:0] num);
      return `VECTOR_BASE + ({12'h000, num} << `VECTOR_STEP_SHIFT);
   endfunction : vec_of

   // Two flip-flops on each external pin; only stage two is read
   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         ext0_sync_q <= 2'h0;
         ext1_sync_q <= 2'h0;
         ext0_prev_q <= 1'b0;
         ext1_prev_q <= 1'b0;
      end else begin
         ext0_sync_q <= {ext0_sync_q[0], external_irq_zero_in};
         ext1_sync_q <= {ext1_sync_q[0], external_irq_one_in};
         ext0_prev_q <= ext0_sync_q[1];
         ext1_prev_q <= ext1_sync_q[1];
      end
   end

   // ****************************************************************
   // Register writes
   // ****************************************************************
   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         irq_enable_reg_q <= `IRQ_ENABLE_RST;
         irq_priority_reg_q <= `IRQ_PRIORITY_RST;
         ext_irq_enable_reg_q <= `EXT_REG_RST;
         ext_irq_priority_reg_q <= `EXT_REG_RST;
         mask_q <= 2'h0;
      end else if (reg_wr_in) begin
         if (reg_addr_in == `IRQ_ENABLE_ADDR) begin
            irq_enable_reg_q <= reg_wdata_in;
         end else if (reg_addr_in == `IRQ_PRIORITY_ADDR) begin
            irq_priority_reg_q <= {1'b1, reg_wdata_in[6:0]}; // Bit 7 reads one
         end else if (reg_addr_in == `EXT_IRQ_ENABLE_ADDR) begin
            ext_irq_enable_reg_q <= reg_wdata_in;
         end else if (reg_addr_in == `EXT_IRQ_PRIORITY_ADDR) begin
            ext_irq_priority_reg_q <= reg_wdata_in;
         end else if (reg_addr_in == `IRQ_MASK_ADDR) begin
            mask_q <= reg_wdata_in[1:0];
         end
      end
   end

   // ****************************************************************
   // Pending flags
   // ****************************************************************
   // Edge events on the external pins; edges give a clean one-shot flag
   always_comb begin
      ext_set = '0;
      ext_set[0] = ext0_sync_q[1] & ~ext0_prev_q;
      ext_set[2] = ext1_sync_q[1] & ~ext1_prev_q;
      hw_clear = '0;
      if (take) begin
         // Only the winner's own flag, and only if it is a self-clearing source
         hw_clear = NUM_SRC'(`HW_CLEAR_MASK) & (NUM_SRC'(1) << arb_num);
      end
      sw_clear = '0;
      if (reg_wr_in && reg_addr_in == `IRQ_PENDING_LO_ADDR) begin
         sw_clear[7:0] = reg_wdata_in;
      end else if (reg_wr_in && reg_addr_in == `IRQ_PENDING_HI_ADDR) begin
         sw_clear[14:8] = reg_wdata_in[6:0];
      end
   end

   // Set wins over clear; flags set regardless of enables
   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         pending_q <= '0;
      end else begin
         pending_q <= ((pending_q & ~hw_clear & ~sw_clear) | src_event_in | ext_set)
                      & ~NUM_SRC'(`RESERVED_SRC_MASK);
      end
   end

   // ****************************************************************
   // Qualification and arbitration
   // ****************************************************************
   always_comb begin
      enable_vec = map_bits(irq_enable_reg_q, ext_irq_enable_reg_q);
      prio_vec = map_bits(irq_priority_reg_q, ext_irq_priority_reg_q);
      enable_vec[6] = irq_enable_reg_q[`SERIAL_EN_BIT];
      req_vec = pending_q & enable_vec & ~NUM_SRC'(`RESERVED_SRC_MASK);
      if (!irq_enable_reg_q[`GLOBAL_EN_BIT]) begin
         req_vec = '0;
      end
   end

   irq_arbiter #(
      .NUM_SRC(NUM_SRC)
   ) u_arbiter (
      .req_in(req_vec),
      .high_in(prio_vec),
      .valid_out(arb_valid),
      .win_high_out(arb_high),
      .win_num_out(arb_num)
   );

   // Decoded every cycle; low may preempt nothing, high preempts only low
   always_comb begin
      take = 1'b0;
      if (arb_valid && !active_high_q && (arb_high || !active_low_q)) begin
         take = (state_q == ST_IDLE || state_q == ST_SERVICE) && instr_done_in;
         if (state_q == ST_AFTER_RETURN) begin
            take = instr_done_in;
         end
      end
   end

   // ****************************************************************
   // Sequencer
   // ****************************************************************
   // Return takes its own cycles in the core; counted as the core reports
   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         state_q <= ST_IDLE;
         call_cnt_q <= 3'h0;
         call_high_q <= 1'b0;
         active_low_q <= 1'b0;
         active_high_q <= 1'b0;
      end else begin
         case (state_q)
            ST_IDLE, ST_SERVICE, ST_AFTER_RETURN: begin
               if (take) begin
                  state_q <= ST_CALL;
                  call_cnt_q <= 3'(CALL_LEN - 1);
                  call_high_q <= arb_high;
               end else if (state_q == ST_SERVICE && return_from_interrupt_in) begin
                  state_q <= ST_AFTER_RETURN;
                  if (active_high_q) begin
                     active_high_q <= 1'b0;
                  end else begin
                     active_low_q <= 1'b0;
                  end
               end else if (state_q == ST_AFTER_RETURN && instr_done_in) begin
                  state_q <= (active_low_q || active_high_q) ? ST_SERVICE : ST_IDLE;
               end
            end
            ST_CALL: begin
               if (call_cnt_q == 3'h0) begin
                  state_q <= ST_SERVICE;
                  if (call_high_q) begin
                     active_high_q <= 1'b1;
                  end else begin
                     active_low_q <= 1'b1;
                  end
               end else begin
                  call_cnt_q <= call_cnt_q - 3'h1;
               end
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   // Call strobe and vector, registered
   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         call_q <= 1'b0;
         vector_q <= `RESET_VECTOR;
      end else begin
         call_q <= take;
         if (take) begin
            vector_q <= vec_of(arb_num);
         end
      end
   end

   // ****************************************************************
   // Status, interrupt and read port
   // ****************************************************************
   // Bit 0: vector taken, bit 1: request held off by active routine
   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         stat_q <= 2'h0;
      end else begin
         stat_q <= (stat_q & ~((reg_wr_in && reg_addr_in == `IRQ_STATUS_ADDR)
                    ? reg_wdata_in[1:0] : 2'h0))
                   | {arb_valid & ~take & (active_low_q | active_high_q), take};
      end
   end

   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         irq_out <= 1'b0;
         in_service_out <= 1'b0;
      end else begin
         irq_out <= |(stat_q & mask_q);
         in_service_out <= active_low_q | active_high_q;
      end
   end

   // Read data one cycle after the strobe; unmapped reads give zero
   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         reg_rdata_out <= 8'h00;
      end else if (reg_rd_in) begin
         if (reg_addr_in == `IRQ_ENABLE_ADDR) begin
            reg_rdata_out <= irq_enable_reg_q;
         end else if (reg_addr_in == `IRQ_PRIORITY_ADDR) begin
            reg_rdata_out <= irq_priority_reg_q;
         end else if (reg_addr_in == `EXT_IRQ_ENABLE_ADDR) begin
            reg_rdata_out <= ext_irq_enable_reg_q;
         end else if (reg_addr_in == `EXT_IRQ_PRIORITY_ADDR) begin
            reg_rdata_out <= ext_irq_priority_reg_q;
         end else if (reg_addr_in == `IRQ_STATUS_ADDR) begin
            reg_rdata_out <= {6'h00, stat_q};
         end else if (reg_addr_in == `IRQ_MASK_ADDR) begin
            reg_rdata_out <= {6'h00, mask_q};
         end else if (reg_addr_in == `IRQ_PENDING_LO_ADDR) begin
            reg_rdata_out <= pending_q[7:0];
         end else if (reg_addr_in == `IRQ_PENDING_HI_ADDR) begin
            reg_rdata_out <= {1'b0, pending_q[14:8]};
         end else begin
            reg_rdata_out <= 8'h00;
         end
      end else begin
         reg_rdata_out <= 8'h00;
      end
   end

   assign long_call_to_vector_out = call_q;
   assign vector_addr_out = vector_q;
endmodule : irq_priority_vectoring
